// file: hw/flic_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Fifteen sources, each assignable any of four priority levels.
// - UART requests when receive-done or transmit-done flag is set.
// - Capture timer gives eight sources; overflow source ORs byte and word flags.
// - Each capture flag is set by its capture input pin.
// - Compare flags set when capture timer equals the compare value.
// - 8-bit overflow sets byte flag, 16-bit overflow sets word flag.
// - Hardware never clears the nine capture-timer flags; software must.
// - ADC request comes from conversion-done flag; only software clears it.
// - I2C request comes from flag set on each valid status code.
// - Software may clear but never set the conversion-done flag.
// - All other flags set or cleared by software like hardware.
// - Per-source enable: 0 blocks, 1 allows requests.
// - Global gate bit 7 of enable A blocks every request when clear.
// - Level is {high bit, low bit}: 00 lowest up to 11 highest.
// - Grant only when no equal or higher level is in service.
// - Equal or lower level requests wait until the running routine ends.
// - Higher level preempts; preempted routine resumes after return.
// - Enable A: gate, ADC, I2C, UART, timer1, ext1, timer0, ext0.
// - Enable B: overflow, compare 2..0, capture 3..0.
// - Priority low A: bit 7 unused, then same seven sources as enable A.
// - Same-level ties resolved in fixed order, external 0 first.
// - Vectors start at 0003H, eight bytes apart, ending at 0073H.
// - Priority high A mirrors priority low A layout, bit 7 unused.
// - Priority low B: overflow, compare 2..0, capture 3..0.
module flic_ctrl (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // External request pins, asynchronous, active low
    input  wire logic        ext_req_zero_pin_b_in,
    input  wire logic        ext_req_one_pin_b_in,
    // Peripheral event pulses, same clock
    input  wire logic        timer_zero_ovf_in,
    input  wire logic        timer_one_ovf_in,
    input  wire logic        uart_rx_done_in,
    input  wire logic        uart_tx_done_in,
    input  wire logic        i2c_status_valid_in,
    input  wire logic        conv_done_in,
    // Capture timer
    input  wire logic [3:0]  capture_pin_in,
    input  wire logic [15:0] ctimer_val_in,
    input  wire logic        ctimer_tick_in,
    input  wire logic [15:0] cmp_zero_val_in,
    input  wire logic [15:0] cmp_one_val_in,
    input  wire logic [15:0] cmp_two_val_in,
    // Processor core
    output logic             irq_req_out,
    output logic      [15:0] irq_vector_out,
    output logic      [1:0]  irq_level_out,
    input  wire logic        irq_ack_in,
    input  wire logic        irq_return_in,
    output logic      [3:0]  in_service_out
);

    typedef struct packed {
        logic [7:0]  ien_a;
        logic [7:0]  ien_b;
        logic [7:0]  ipl_a;
        logic [7:0]  iph_a;
        logic [7:0]  ipl_b;
        logic [7:0]  iph_b;
        logic [7:0]  flag_a;
        logic [7:0]  flag_b;
        logic        word_ovf;
        logic [3:0]  in_svc;
        logic [7:0]  rdata;
        logic        req;
        logic [15:0] vec;
        logic [1:0]  lvl;
        logic [1:0]  ext0_sync;
        logic [1:0]  ext1_sync;
        logic        ext0_prev;
        logic        ext1_prev;
        logic [3:0]  cap_s1;
        logic [3:0]  cap_s2;
        logic [3:0]  cap_prev;
    } flic_state_s;

    flic_state_s state_q;
    flic_state_s state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Spread a pair of register bytes onto the vector-ordered source index
    function automatic logic [14:0] map15(input logic [7:0] a, input logic [7:0] b);
        map15 = {b[7], b[6:4], a[6], b[3:0], a[5:0]};
    endfunction

    // Highest level currently in service
    function automatic logic [1:0] top_level(input logic [3:0] svc);
        top_level = 2'h0;
        for (int i = 0; i < flic_pkg::NUM_LEVELS; i++) begin
            if (svc[i]) begin
                top_level = 2'(i);
            end
        end
    endfunction

    // Does the capture timer reach this value on the coming tick
    function automatic logic hits(input logic [15:0] tv, input logic [15:0] cv);
        hits = (16'(tv + 16'h0001) == cv);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Source view

    logic [14:0] pend;
    logic [14:0] en15;
    logic [14:0] plo15;
    logic [14:0] phi15;

    // Requests in vector order; UART and overflow each merge two flags
    assign pend = {state_q.flag_b[7] | state_q.word_ovf,
                   state_q.flag_b[6:4],
                   state_q.flag_a[flic_pkg::FA_ADC],
                   state_q.flag_b[3:0],
                   state_q.flag_a[flic_pkg::FA_I2C],
                   state_q.flag_a[flic_pkg::FA_UART_TX] | state_q.flag_a[flic_pkg::FA_UART_RX],
                   state_q.flag_a[3:0]};
    assign en15  = map15(state_q.ien_a, state_q.ien_b);
    assign plo15 = map15(state_q.ipl_a, state_q.ipl_b);
    assign phi15 = map15(state_q.iph_a, state_q.iph_b);

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    logic       found;
    logic [3:0] best_idx;
    logic [1:0] best_lvl;
    logic       grant;

    // Highest level first, fixed order inside a level
    always_comb begin
        logic [3:0] idx;
        idx      = 4'h0;
        found    = 1'b0;
        best_idx = 4'h0;
        best_lvl = 2'h0;
        for (int lv = flic_pkg::NUM_LEVELS - 1; lv >= 0; lv--) begin
            for (int k = 0; k < flic_pkg::NUM_SRC; k++) begin
                idx = flic_pkg::prio_order(k);
                if (!found && pend[idx] && en15[idx] && ({phi15[idx], plo15[idx]} == 2'(lv))) begin
                    found    = 1'b1;
                    best_idx = idx;
                    best_lvl = 2'(lv);
                end
            end
        end
    end

    // Only a strictly higher level may interrupt what runs now
    assign grant = found && state_q.ien_a[flic_pkg::GLOBAL_GATE_BIT]
                   && ((state_q.in_svc == 4'h0) || (best_lvl > top_level(state_q.in_svc)));

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [3:0] svc;
        svc     = state_q.in_svc;
        state_d = state_q;

        // Pin synchronisers; only the second stage feeds edge logic
        state_d.ext0_sync = {state_q.ext0_sync[0], ext_req_zero_pin_b_in};
        state_d.ext1_sync = {state_q.ext1_sync[0], ext_req_one_pin_b_in};
        state_d.ext0_prev = state_q.ext0_sync[1];
        state_d.ext1_prev = state_q.ext1_sync[1];
        state_d.cap_s1    = capture_pin_in;
        state_d.cap_s2    = state_q.cap_s1;
        state_d.cap_prev  = state_q.cap_s2;

        // Software writes
        if (wr_in) begin
            case (addr_in)
                flic_pkg::ADDR_IRQ_ENABLE_A:        state_d.ien_a = wdata_in;
                flic_pkg::ADDR_IRQ_ENABLE_B:        state_d.ien_b = wdata_in;
                flic_pkg::ADDR_IRQ_PRIORITY_LOW_A:  state_d.ipl_a = wdata_in & 8'h7F;
                flic_pkg::ADDR_IRQ_PRIORITY_HIGH_A: state_d.iph_a = wdata_in & 8'h7F;
                flic_pkg::ADDR_IRQ_PRIORITY_LOW_B:  state_d.ipl_b = wdata_in;
                flic_pkg::ADDR_IRQ_PRIORITY_HIGH_B: state_d.iph_b = wdata_in;
                flic_pkg::ADDR_FLAG_A: begin
                    // Conversion-done bit can only be cleared by software
                    state_d.flag_a = {wdata_in[7] & state_q.flag_a[7], wdata_in[6:0]};
                end
                flic_pkg::ADDR_FLAG_B:              state_d.flag_b = wdata_in;
                flic_pkg::ADDR_FLAG_C:              state_d.word_ovf = wdata_in[0];
                default: ;
            endcase
        end

        // Hardware sets come after writes so a same-cycle event wins
        if (state_q.ext0_prev && !state_q.ext0_sync[1]) state_d.flag_a[0] = 1'b1;
        if (timer_zero_ovf_in)                          state_d.flag_a[1] = 1'b1;
        if (state_q.ext1_prev && !state_q.ext1_sync[1]) state_d.flag_a[2] = 1'b1;
        if (timer_one_ovf_in)                           state_d.flag_a[3] = 1'b1;
        if (uart_rx_done_in)     state_d.flag_a[flic_pkg::FA_UART_RX] = 1'b1;
        if (uart_tx_done_in)     state_d.flag_a[flic_pkg::FA_UART_TX] = 1'b1;
        if (i2c_status_valid_in) state_d.flag_a[flic_pkg::FA_I2C]     = 1'b1;
        if (conv_done_in)        state_d.flag_a[flic_pkg::FA_ADC]     = 1'b1;
        state_d.flag_b[3:0] = state_d.flag_b[3:0] | (state_q.cap_s2 & ~state_q.cap_prev);
        if (ctimer_tick_in) begin
            if (hits(ctimer_val_in, cmp_zero_val_in)) state_d.flag_b[4] = 1'b1;
            if (hits(ctimer_val_in, cmp_one_val_in))  state_d.flag_b[5] = 1'b1;
            if (hits(ctimer_val_in, cmp_two_val_in))  state_d.flag_b[6] = 1'b1;
            if (ctimer_val_in[7:0] == flic_pkg::BYTE_MAX) state_d.flag_b[flic_pkg::FB_BYTE_OVF] = 1'b1;
            if (ctimer_val_in == flic_pkg::WORD_MAX)      state_d.word_ovf = 1'b1;
        end

        // Return retires the highest running level, grant marks the new one
        if (irq_return_in && (svc != 4'h0)) begin
            svc[top_level(svc)] = 1'b0;
        end
        if (irq_ack_in && state_q.req) begin
            svc[state_q.lvl] = 1'b1;
        end
        state_d.in_svc = svc;

        // Request is held off for one cycle after an ack to settle in-service
        state_d.req = grant && !irq_ack_in && !irq_return_in;
        state_d.vec = 16'(flic_pkg::VEC_BASE + 16'(best_idx) * flic_pkg::VEC_STRIDE);
        state_d.lvl = best_lvl;

        // Read data stands in the cycle after the strobe only
        state_d.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                flic_pkg::ADDR_IRQ_ENABLE_A:        state_d.rdata = state_q.ien_a;
                flic_pkg::ADDR_IRQ_ENABLE_B:        state_d.rdata = state_q.ien_b;
                flic_pkg::ADDR_IRQ_PRIORITY_LOW_A:  state_d.rdata = state_q.ipl_a;
                flic_pkg::ADDR_IRQ_PRIORITY_HIGH_A: state_d.rdata = state_q.iph_a;
                flic_pkg::ADDR_IRQ_PRIORITY_LOW_B:  state_d.rdata = state_q.ipl_b;
                flic_pkg::ADDR_IRQ_PRIORITY_HIGH_B: state_d.rdata = state_q.iph_b;
                flic_pkg::ADDR_FLAG_A:              state_d.rdata = state_q.flag_a;
                flic_pkg::ADDR_FLAG_B:              state_d.rdata = state_q.flag_b;
                flic_pkg::ADDR_FLAG_C:              state_d.rdata = {7'h00, state_q.word_ovf};
                flic_pkg::ADDR_SERVICE_STATUS:      state_d.rdata = {3'h0, state_q.req, state_q.in_svc};
                default:                            state_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q           <= '0;
            state_q.ien_a     <= flic_pkg::REG_RESET;
            state_q.ext0_sync <= 2'h3;
            state_q.ext1_sync <= 2'h3;
            state_q.ext0_prev <= 1'b1;
            state_q.ext1_prev <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign rdata_out      = state_q.rdata;
    assign irq_req_out    = state_q.req;
    assign irq_vector_out = state_q.vec;
    assign irq_level_out  = state_q.lvl;
    assign in_service_out = state_q.in_svc;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    logic [3:0] req_idx;
    assign req_idx = state_q.vec[6:3];

    AST_GATE_BLOCKS: assert property (!state_q.ien_a[7] |=> !irq_req_out)
        else $error("request raised with global gate clear");

    AST_ADC_NO_SW_SET: assert property (
        wr_in && addr_in == flic_pkg::ADDR_FLAG_A && wdata_in[7] && !state_q.flag_a[7] && !conv_done_in
        |=> !state_q.flag_a[7])
        else $error("software set the conversion-done flag");

    AST_T2_STICKY: assert property (
        state_q.flag_b[4] && !(wr_in && addr_in == flic_pkg::ADDR_FLAG_B) |=> state_q.flag_b[4])
        else $error("compare flag cleared without software");

    AST_ACK_MARKS: assert property (irq_ack_in && irq_req_out |=> in_service_out[$past(irq_level_out)])
        else $error("grant did not mark in-service level");

    AST_STRICTLY_HIGHER: assert property (
        irq_req_out |-> (in_service_out == 4'h0) || (irq_level_out > top_level(in_service_out)))
        else $error("request at level not above running level");

    AST_LEVEL_MATCH: assert property (
        irq_req_out && $stable(state_q.iph_a) && $stable(state_q.ipl_a) && $stable(state_q.iph_b)
        && $stable(state_q.ipl_b) |-> irq_level_out == {phi15[req_idx], plo15[req_idx]})
        else $error("level does not match priority bits");

    AST_WORD_OVF: assert property (ctimer_tick_in && ctimer_val_in == 16'hFFFF |=> state_q.word_ovf)
        else $error("word overflow not flagged");

    AST_CMP_SET: assert property (ctimer_tick_in && hits(ctimer_val_in, cmp_zero_val_in)
        |=> state_q.flag_b[flic_pkg::FB_CMP0])
        else $error("compare match not flagged");

    AST_RETURN_POPS: assert property (
        irq_return_in && !irq_ack_in && in_service_out == 4'h3 |=> in_service_out == 4'h1)
        else $error("return did not retire highest level");

    AST_VEC_FORM: assert property (
        irq_req_out |-> irq_vector_out[2:0] == 3'h3 && irq_vector_out <= flic_pkg::VEC_LAST)
        else $error("vector outside table");

    AST_UART_EITHER: assert property (
        state_q.ien_a == 8'h90 && state_q.in_svc == 4'h0 && state_q.flag_a == 8'h20 && !irq_ack_in
        && !irq_return_in |=> irq_req_out && irq_vector_out == 16'h0023)
        else $error("uart transmit flag alone did not request");

    COV_NESTED: cover property (in_service_out == 4'hF);
    COV_PREEMPT: cover property (irq_req_out && in_service_out != 4'h0);
    COV_TIE: cover property (irq_req_out && $countones(pend & en15) > 1);
    COV_ADC: cover property (irq_ack_in && irq_vector_out == 16'h0053);

endmodule
`default_nettype wire

// file: hw/flic_pkg.sv
`default_nettype none
package flic_pkg;
    // Register map, byte offsets on the 8-bit register port
    localparam logic [7:0] ADDR_IRQ_ENABLE_A        = 8'hA8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_LOW_A  = 8'hB8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_HIGH_A = 8'hB7;
    localparam logic [7:0] ADDR_IRQ_ENABLE_B        = 8'hE8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_LOW_B  = 8'hF8;
    localparam logic [7:0] ADDR_IRQ_PRIORITY_HIGH_B = 8'hF7;
    localparam logic [7:0] ADDR_FLAG_A              = 8'hC0;
    localparam logic [7:0] ADDR_FLAG_B              = 8'hC8;
    localparam logic [7:0] ADDR_FLAG_C              = 8'hC9;
    localparam logic [7:0] ADDR_SERVICE_STATUS      = 8'hCA;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int GLOBAL_GATE_BIT = 7;
    localparam int PRIO_A_USED     = 7;
    localparam int FA_UART_RX      = 4;
    localparam int FA_UART_TX      = 5;
    localparam int FA_I2C          = 6;
    localparam int FA_ADC          = 7;
    localparam int FB_CMP0         = 4;
    localparam int FB_BYTE_OVF     = 7;

    // Sources and levels
    localparam int NUM_SRC    = 15;
    localparam int NUM_LEVELS = 4;

    // Vectors: base plus stride times source index
    localparam logic [15:0] VEC_BASE   = 16'h0003;
    localparam logic [15:0] VEC_STRIDE = 16'h0008;
    localparam logic [15:0] VEC_LAST   = 16'h0073;

    // Timer limits for overflow detection
    localparam logic [7:0]  BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

    // Source index (vector order) granted k-th within one level
    function automatic logic [3:0] prio_order(input int k);
        case (k)
            0:  prio_order = 4'h0;
            1:  prio_order = 4'h5;
            2:  prio_order = 4'hA;
            3:  prio_order = 4'h1;
            4:  prio_order = 4'h6;
            5:  prio_order = 4'hB;
            6:  prio_order = 4'h2;
            7:  prio_order = 4'h7;
            8:  prio_order = 4'hC;
            9:  prio_order = 4'h3;
            10: prio_order = 4'h8;
            11: prio_order = 4'hD;
            12: prio_order = 4'h4;
            13: prio_order = 4'h9;
            default: prio_order = 4'hE;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: test/flic_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural core: takes each grant after a set delay, returns on command
module flic_core_model (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_b_in,
    // Controller side
    input  wire logic        req_in,
    input  wire logic [15:0] vector_in,
    input  wire logic [1:0]  level_in,
    output logic             ack_out,
    output logic             return_out,
    // Bench side
    input  wire logic [2:0]  ack_delay_in,
    input  wire logic        ret_cmd_in,
    output logic      [15:0] last_vector_out,
    output logic      [1:0]  last_level_out,
    output logic      [7:0]  n_ack_out,
    output logic      [2:0]  depth_out
);
    logic [2:0] wait_q;

    ////////////////////////////////////////////////////////////////////////
    // Ack only while a request stands, so a dropped request is never taken
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_out         <= 1'b0;
            return_out      <= 1'b0;
            wait_q          <= 3'h0;
            last_vector_out <= 16'h0000;
            last_level_out  <= 2'h0;
            n_ack_out       <= 8'h00;
            depth_out       <= 3'h0;
        end else begin
            return_out <= ret_cmd_in && (depth_out != 3'h0);
            depth_out  <= depth_out + {2'b0, ack_out & req_in} - {2'b0, return_out};
            if (ack_out) begin
                ack_out <= 1'b0;
                if (req_in) begin
                    last_vector_out <= vector_in;
                    last_level_out  <= level_in;
                    n_ack_out       <= n_ack_out + 8'h01;
                end
            end else if (req_in && wait_q >= ack_delay_in) begin
                ack_out <= 1'b1;
                wait_q  <= 3'h0;
            end else if (req_in) begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/tb_flic_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_flic_ctrl;
    // Per source {flag address, flag bit, enable bit}, in vector order
    localparam logic [15:0] SMAP [15] = '{16'hC000, 16'hC011, 16'hC022, 16'hC033, 16'hC054, 16'hC065,
        16'hC800, 16'hC811, 16'hC822, 16'hC833, 16'hC076, 16'hC844, 16'hC855, 16'hC866, 16'hC907};
    localparam logic [7:0]  RADDR [11] = '{8'hA8, 8'hE8, 8'hF8, 8'hF7, 8'hB8, 8'hB7, 8'hC0, 8'hC8, 8'hC9,
        8'hCA, 8'h10};
    localparam logic [15:0] TIE [3]  = '{16'h002B, 16'h0033, 16'h0013};
    localparam logic [15:0] TCLR [3] = '{16'hC004, 16'hC800, 16'hC000};
    logic        mclk_in, rst_b_in, wr, rd, tick, req, ack, ret, ret_cmd, isa;
    logic [7:0]  addr, wdata, rdata, n_ack, eb;
    logic [15:0] tval, vec, last_vec, m, cmp0, cmp1, cmp2;
    logic [1:0]  ext_b, lvl, last_lvl, lv;
    logic [5:0]  ev;
    logic [3:0]  cap, insvc;
    logic [2:0]  ack_delay;
    int          n_fail;
    int          compares;

    flic_ctrl dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .ext_req_zero_pin_b_in(ext_b[0]), .ext_req_one_pin_b_in(ext_b[1]),
        .timer_zero_ovf_in(ev[0]), .timer_one_ovf_in(ev[1]), .uart_rx_done_in(ev[2]), .uart_tx_done_in(ev[3]),
        .i2c_status_valid_in(ev[4]), .conv_done_in(ev[5]), .capture_pin_in(cap), .ctimer_val_in(tval),
        .ctimer_tick_in(tick), .cmp_zero_val_in(cmp0), .cmp_one_val_in(cmp1), .cmp_two_val_in(cmp2),
        .irq_req_out(req), .irq_vector_out(vec), .irq_level_out(lvl), .irq_ack_in(ack),
        .irq_return_in(ret), .in_service_out(insvc));
    flic_core_model core (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .req_in(req), .vector_in(vec),
        .level_in(lvl), .ack_out(ack), .return_out(ret), .ack_delay_in(ack_delay), .ret_cmd_in(ret_cmd),
        .last_vector_out(last_vec), .last_level_out(last_lvl), .n_ack_out(n_ack), .depth_out());

    ////////////////////////////////////////////////////////////////////////
    // Shared bus and compare tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp}, "read");
    endtask
    task automatic pulse(input int k);
        @(posedge mclk_in);
        ev[k] <= 1'b1;
        @(posedge mclk_in);
        ev[k] <= 1'b0;
    endtask
    task automatic tick_at(input logic [15:0] v);
        @(posedge mclk_in);
        tval <= v;
        tick <= 1'b1;
        @(posedge mclk_in);
        tick <= 1'b0;
    endtask
    // Bounded wait for the core model to take one more grant
    task automatic wait_ack();
        logic [7:0] n0;
        n0 = n_ack;
        for (int k = 0; k < 200 && n_ack === n0; k++) @(posedge mclk_in);
        #1;
        check({8'h00, n_ack}, {8'h00, n0 + 8'h01}, "grant");
    endtask
    task automatic retire();
        @(posedge mclk_in);
        ret_cmd <= 1'b1;
        @(posedge mclk_in);
        ret_cmd <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic no_req(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
        check({15'h0, req}, 16'h0000, "request");
    endtask
    task automatic stop_test();
        if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the run needs a few thousand cycles at most
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (30000) @(posedge mclk_in);
        n_fail++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {rst_b_in, wr, rd, tick, ret_cmd, ev, cap, tval, addr, wdata, ack_delay} = '0;
        {ext_b, cmp0, cmp1, cmp2} = {2'b11, 16'h0010, 16'h0020, 16'h0030};
        n_fail = 0;
        compares = 0;
        repeat (4) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        foreach (RADDR[j]) rd_chk(RADDR[j], 8'h00);
        for (int j = 0; j < 6; j++) begin
            wr_reg(RADDR[j], 8'hFF);
            rd_chk(RADDR[j], (j > 3) ? 8'h7F : 8'hFF);
            wr_reg(RADDR[j], 8'h00);
        end
        wr_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        // Software flags: conversion flag cannot be set, the rest can
        wr_reg(8'hC0, 8'hFF);
        rd_chk(8'hC0, 8'h7F);
        wr_reg(8'hC8, 8'hFF);
        wr_reg(8'hC9, 8'h01);
        no_req(6);
        wr_reg(8'hA8, 8'h7F);
        wr_reg(8'hE8, 8'hFF);
        no_req(6);
        for (int j = 0; j < 3; j++) wr_reg(RADDR[j + 6], 8'h00);
        wr_reg(8'hA8, 8'h00);
        wr_reg(8'hE8, 8'h00);
        // Hardware sets; nothing clears them but software
        for (int k = 0; k < 6; k++) pulse(k);
        ext_b <= 2'b00;
        cap   <= 4'hF;
        repeat (6) @(posedge mclk_in);
        rd_chk(8'hC8, 8'h0F);
        tick_at(16'h000F);
        tick_at(16'h001F);
        tick_at(16'h002F);
        tick_at(16'h00FF);
        rd_chk(8'hC9, 8'h00);
        rd_chk(8'hC8, 8'hFF);
        tick_at(16'hFFFF);
        rd_chk(8'hC9, 8'h01);
        repeat (20) @(posedge mclk_in);
        rd_chk(8'hC0, 8'hFF);
        rd_chk(8'hC8, 8'hFF);
        for (int j = 0; j < 3; j++) wr_reg(RADDR[j + 6], 8'h00);
        rd_chk(8'hC0, 8'h00);
        // Every source alone: enable, level, vector, service record
        for (int i = 0; i < 15; i++) begin
            m = SMAP[i];
            isa = (m[15:8] == 8'hC0);
            lv = 2'(i % 4);
            eb = 8'h01 << m[3:0];
            ack_delay <= 3'(i % 8);
            wr_reg(8'hA8, isa ? (8'h80 | eb) : 8'h80);
            wr_reg(8'hE8, isa ? 8'h00 : eb);
            wr_reg(isa ? 8'hB8 : 8'hF8, lv[0] ? eb : 8'h00);
            wr_reg(isa ? 8'hB7 : 8'hF7, lv[1] ? eb : 8'h00);
            if (i == 10) pulse(5);
            else wr_reg(m[15:8], 8'h01 << m[7:4]);
            wait_ack();
            check(last_vec, 16'h0003 + 16'(8 * i), "vector");
            check({14'h0, last_lvl}, {14'h0, lv}, "level");
            check({12'h0, insvc}, 16'(1 << lv), "in service");
            wr_reg(m[15:8], 8'h00);
            retire();
            check({12'h0, insvc}, 16'h0000, "retired");
        end
        // Nesting: uart and ext1 at level 1, capture 0 at level 2
        ack_delay <= 3'h3;
        for (int j = 0; j < 6; j++) wr_reg(RADDR[j], 8'(48'h9401_0001_1400 >> (8 * (5 - j))));
        wr_reg(8'hC0, 8'h20);
        wait_ack();
        check(last_vec, 16'h0023, "uart grant");
        wr_reg(8'hC0, 8'h24);
        no_req(10);
        wr_reg(8'hC8, 8'h01);
        wait_ack();
        check(last_vec, 16'h0033, "preempt");
        check({12'h0, insvc}, 16'h0006, "nested");
        rd_chk(8'hC8, 8'h01);
        wr_reg(8'hC8, 8'h00);
        retire();
        check({12'h0, insvc}, 16'h0002, "resumed");
        no_req(6);
        wr_reg(8'hC0, 8'h04);
        retire();
        wait_ack();
        check(last_vec, 16'h0013, "held request");
        wr_reg(8'hC0, 8'h00);
        retire();
        // Same level ties, released together by the global gate
        ack_delay <= 3'h5;
        wr_reg(8'hA8, 8'h24);
        wr_reg(8'hB8, 8'h00);
        wr_reg(8'hF7, 8'h00);
        wr_reg(8'hC8, 8'h01);
        wr_reg(8'hC0, 8'h44);
        no_req(4);
        wr_reg(8'hA8, 8'hA4);
        for (int j = 0; j < 3; j++) begin
            wait_ack();
            check(last_vec, TIE[j], "tie order");
            wr_reg(TCLR[j][15:8], TCLR[j][7:0]);
            retire();
        end
        stop_test();
    end
endmodule
`default_nettype wire
